// ===== design/round_rotate_regs.svh
`ifndef ROUND_ROTATE_REGS_SVH
`define ROUND_ROTATE_REGS_SVH

// Register byte offsets on the bus.
`define OFF_CTRL       8'h00
`define OFF_MODE       8'h04
`define OFF_ACC_EXT    8'h08
`define OFF_ACC_UPPER  8'h0C
`define OFF_ACC_LOWER  8'h10
`define OFF_WORD       8'h14
`define OFF_CCR        8'h18

// Command register fields.
`define CTRL_OP_LSB    0
`define CTRL_DST_BIT   2
`define CTRL_LIM_BIT   3
`define CTRL_MV_LSB    4
`define OPC_ROUND      2'h1
`define OPC_ROL        2'h2
`define OPC_ROR        2'h3

// Operating mode register fields and reset value.
`define MODE_RND_BIT   0
`define MODE_CCW_BIT   1
`define MODE_RESET     2'h0

// Condition code bits; the busy bit reads beside them.
`define CCR_C          0
`define CCR_V          1
`define CCR_Z          2
`define CCR_N          3
`define CCR_U          4
`define CCR_E          5
`define CCR_L          6
`define CCR_SZ         7
`define CCR_BUSY       8
`define CCR_RESET      8'h00

// Arithmetic constants and timing.
`define ROUND_CONST    36'h000008000
`define HALF_LOWER     16'h8000
`define OP_CYCLES      2

`endif

// ===== design/round_rotate_pkg.sv
`default_nettype none

package round_rotate_pkg;

    typedef enum logic [1:0] {
        no_op,
        round_accumulator_op,
        rotate_left_op,
        rotate_right_op
    } op_e;

    typedef enum logic [1:0] {
        ph_idle,
        ph_exec,
        ph_commit
    } phase_e;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        phase_e      phase;
        logic [3:0]  mvcnt;
        op_e         op;
        logic        dst_word;
        logic        lim;
        logic        rnd_sel;
        logic        cc_width;
        logic [3:0]  extension_portion;
        logic [15:0] upper_word;
        logic [15:0] lower_word;
        logic [15:0] word;
        logic [7:0]  ccr;
    } state_s;

endpackage

`default_nettype wire

// ===== design/round_accumulator_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "round_rotate_regs.svh"

module round_accumulator_unit (
    input  wire logic [35:0] acc_i,
    input  wire logic        rnd_sel_i,
    input  wire logic        cc_width_i,
    input  wire logic        lim_i,
    output logic      [35:0] result_o,
    output logic             neg_o,
    output logic             zero_o,
    output logic             ovf_o,
    output logic             ext_o,
    output logic             unnorm_o,
    output logic             size_flag_o,
    output logic             limit_o
);
    logic [35:0] sum;

    always_comb begin
        sum = acc_i + `ROUND_CONST;
        // Convergent mode breaks an exact tie toward an even upper word.
        if (!rnd_sel_i && acc_i[15:0] == `HALF_LOWER) begin
            sum[16] = 1'b0;
        end
        result_o = {sum[35:16], 16'h0000};
        ovf_o = ~acc_i[35] & sum[35];
        limit_o = lim_i | ovf_o;
        ext_o = ~(&result_o[35:31] | ~(|result_o[35:31]));
        unnorm_o = ~(result_o[31] ^ result_o[30]);
        size_flag_o = result_o[30] ^ result_o[29];
        // On overflow the wrapped sign is wrong, so with cc_width_i low the true sign is shown.
        if (cc_width_i) begin
            neg_o = result_o[31];
            zero_o = (result_o[31:0] == 32'h00000000);
        end else begin
            neg_o = ovf_o ? acc_i[35] : result_o[35];
            zero_o = (result_o == 36'h000000000);
        end
    end

endmodule
`default_nettype wire

// ===== design/rotate_word_unit.sv
`timescale 1ns/10ps
`default_nettype none

module rotate_word_unit (
    input  wire logic [15:0] word_i,
    input  wire logic        carry_i,
    input  wire logic        left_i,
    output logic      [15:0] result_o,
    output logic             carry_o,
    output logic             neg_o,
    output logic             zero_o
);
    always_comb begin
        if (left_i) begin
            result_o = {word_i[14:0], carry_i};
            carry_o = word_i[15];
        end else begin
            result_o = {carry_i, word_i[15:1]};
            carry_o = word_i[0];
        end
        neg_o = result_o[15];
        zero_o = (result_o == 16'h0000);
    end

endmodule
`default_nettype wire

// ===== design/accumulator_round_rotate_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "round_rotate_regs.svh"

module accumulator_round_rotate_unit (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             busy_o
);
    round_rotate_pkg::state_s st;
    round_rotate_pkg::state_s nx;

    logic [35:0] acc;
    logic [35:0] rnd_result;
    logic        rnd_neg;
    logic        rnd_zero;
    logic        rnd_ovf;
    logic        rnd_ext;
    logic        rnd_unnorm;
    logic        rnd_size;
    logic        rnd_limit;
    logic [15:0] rot_in;
    logic [15:0] rot_result;
    logic        rot_carry;
    logic        rot_neg;
    logic        rot_zero;
    logic        take;
    logic [7:0]  offset;
    logic [31:0] rd_mux;
    logic [35:0] plain_sum;

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  sel
    );
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    assign acc = {st.extension_portion, st.upper_word, st.lower_word};
    assign rot_in = st.dst_word ? st.word : st.upper_word;
    assign take = cyc_i & stb_i & st.ack;
    assign offset = {adr_i[7:2], 2'h0};
    assign plain_sum = acc + `ROUND_CONST;

    round_accumulator_unit round_accumulator_unit_inst (
        .acc_i       (acc),
        .rnd_sel_i   (st.rnd_sel),
        .cc_width_i  (st.cc_width),
        .lim_i       (st.lim),
        .result_o    (rnd_result),
        .neg_o       (rnd_neg),
        .zero_o      (rnd_zero),
        .ovf_o       (rnd_ovf),
        .ext_o       (rnd_ext),
        .unnorm_o    (rnd_unnorm),
        .size_flag_o (rnd_size),
        .limit_o     (rnd_limit)
    );

    rotate_word_unit rotate_word_unit_inst (
        .word_i   (rot_in),
        .carry_i  (st.ccr[`CCR_C]),
        .left_i   (st.op == round_rotate_pkg::rotate_left_op),
        .result_o (rot_result),
        .carry_o  (rot_carry),
        .neg_o    (rot_neg),
        .zero_o   (rot_zero)
    );

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 32'h00000000;
        case (offset)
            `OFF_MODE: begin
                rd_mux[`MODE_RND_BIT] = st.rnd_sel;
                rd_mux[`MODE_CCW_BIT] = st.cc_width;
            end
            `OFF_ACC_EXT: begin
                rd_mux[3:0] = st.extension_portion;
            end
            `OFF_ACC_UPPER: begin
                rd_mux[15:0] = st.upper_word;
            end
            `OFF_ACC_LOWER: begin
                rd_mux[15:0] = st.lower_word;
            end
            `OFF_WORD: begin
                rd_mux[15:0] = st.word;
            end
            `OFF_CCR: begin
                rd_mux[7:0] = st.ccr;
                rd_mux[`CCR_BUSY] = (st.phase != round_rotate_pkg::ph_idle);
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        nx = st;
        nx.ack = cyc_i & stb_i & ~st.ack;
        if (cyc_i && stb_i && !st.ack) begin
            nx.rdat = rd_mux;
        end
        // Writes while an operation runs are dropped so that software can
        // never race the commit of an operand or a flag.
        if (take && we_i && st.phase == round_rotate_pkg::ph_idle) begin
            case (offset)
                `OFF_CTRL: begin
                    if (sel_i[0]) begin
                        nx.dst_word = dat_i[`CTRL_DST_BIT];
                        nx.lim = dat_i[`CTRL_LIM_BIT];
                        nx.mvcnt = dat_i[`CTRL_MV_LSB +: 4];
                        nx.phase = round_rotate_pkg::ph_exec;
                        case (dat_i[`CTRL_OP_LSB +: 2])
                            `OPC_ROUND: begin
                                nx.op = round_rotate_pkg::round_accumulator_op;
                            end
                            `OPC_ROL: begin
                                nx.op = round_rotate_pkg::rotate_left_op;
                            end
                            `OPC_ROR: begin
                                nx.op = round_rotate_pkg::rotate_right_op;
                            end
                            default: begin
                                nx.op = round_rotate_pkg::no_op;
                                nx.phase = round_rotate_pkg::ph_idle;
                            end
                        endcase
                    end
                end
                `OFF_MODE: begin
                    if (sel_i[0]) begin
                        nx.rnd_sel = dat_i[`MODE_RND_BIT];
                        nx.cc_width = dat_i[`MODE_CCW_BIT];
                    end
                end
                `OFF_ACC_EXT: begin
                    if (sel_i[0]) begin
                        nx.extension_portion = dat_i[3:0];
                    end
                end
                `OFF_ACC_UPPER: begin
                    nx.upper_word = merge16(st.upper_word, dat_i, sel_i);
                end
                `OFF_ACC_LOWER: begin
                    nx.lower_word = merge16(st.lower_word, dat_i, sel_i);
                end
                `OFF_WORD: begin
                    nx.word = merge16(st.word, dat_i, sel_i);
                end
                `OFF_CCR: begin
                    if (sel_i[0]) begin
                        nx.ccr = dat_i[7:0];
                    end
                end
                default: begin
                    nx.ccr = st.ccr;
                end
            endcase
        end
        case (st.phase)
            round_rotate_pkg::ph_idle: begin
                nx.mvcnt = nx.mvcnt;
            end
            round_rotate_pkg::ph_exec: begin
                // Rounds hold here for the parallel move's extra cycles.
                if (st.op == round_rotate_pkg::round_accumulator_op &&
                    st.mvcnt != 4'h0) begin
                    nx.mvcnt = st.mvcnt - 4'h1;
                end else begin
                    nx.phase = round_rotate_pkg::ph_commit;
                end
            end
            round_rotate_pkg::ph_commit: begin
                nx.phase = round_rotate_pkg::ph_idle;
                if (st.op == round_rotate_pkg::round_accumulator_op) begin
                    nx.extension_portion = rnd_result[35:32];
                    nx.upper_word = rnd_result[31:16];
                    nx.lower_word = 16'h0000;
                    nx.ccr[`CCR_N] = rnd_neg;
                    nx.ccr[`CCR_Z] = rnd_zero;
                    nx.ccr[`CCR_V] = rnd_ovf;
                    nx.ccr[`CCR_E] = rnd_ext;
                    nx.ccr[`CCR_U] = rnd_unnorm;
                    // Limit and size flags are sticky until software clears.
                    nx.ccr[`CCR_L] = st.ccr[`CCR_L] | rnd_limit;
                    nx.ccr[`CCR_SZ] = st.ccr[`CCR_SZ] | rnd_size;
                end else if (st.op != round_rotate_pkg::no_op) begin
                    if (st.dst_word) begin
                        nx.word = rot_result;
                    end else begin
                        nx.upper_word = rot_result;
                    end
                    nx.ccr[`CCR_C] = rot_carry;
                    nx.ccr[`CCR_N] = rot_neg;
                    nx.ccr[`CCR_Z] = rot_zero;
                    nx.ccr[`CCR_V] = 1'b0;
                end
            end
            default: begin
                nx.phase = round_rotate_pkg::ph_idle;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.phase <= round_rotate_pkg::ph_idle;
            st.op <= round_rotate_pkg::no_op;
            st.rnd_sel <= 1'(`MODE_RESET >> `MODE_RND_BIT);
            st.cc_width <= 1'(`MODE_RESET >> `MODE_CCW_BIT);
            st.ccr <= `CCR_RESET;
        end else begin
            st <= nx;
        end
    end

    assign ack_o = st.ack;
    assign dat_o = st.rdat;
    assign busy_o = (st.phase != round_rotate_pkg::ph_idle);

    logic commit_rnd;
    logic commit_rot;
    logic start_op;
    logic [4:0] int_bits;

    assign int_bits = {st.extension_portion, st.upper_word[15]};

    assign commit_rnd = st.phase == round_rotate_pkg::ph_commit &&
                        st.op == round_rotate_pkg::round_accumulator_op;
    assign commit_rot = st.phase == round_rotate_pkg::ph_commit &&
                        st.op != round_rotate_pkg::round_accumulator_op;
    assign start_op = st.phase == round_rotate_pkg::ph_idle &&
                      nx.phase == round_rotate_pkg::ph_exec;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_SINGLE: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");
    AST_ROT_TIME: assert property (
        (start_op && nx.op != round_rotate_pkg::round_accumulator_op)
        |=> busy_o ##1 busy_o ##1 !busy_o)
        else $error("rotate did not finish in two cycles");
    AST_RND_TIME: assert property (
        (start_op && nx.op == round_rotate_pkg::round_accumulator_op &&
         nx.mvcnt == 4'h0) |=> busy_o ##1 busy_o ##1 !busy_o)
        else $error("round without move did not finish in two cycles");
    AST_RND_LOWER: assert property (
        commit_rnd |=> st.lower_word == 16'h0000)
        else $error("round left the lower word nonzero");
    AST_RND_TIE: assert property (
        (commit_rnd && !st.rnd_sel && st.lower_word == `HALF_LOWER)
        |=> !st.upper_word[0])
        else $error("convergent tie did not round to even");
    AST_RND_TWOS: assert property (
        (commit_rnd && st.rnd_sel)
        |=> {st.extension_portion, st.upper_word} == $past(plain_sum[35:16]))
        else $error("two's-complement round is not the plain sum");
    AST_ROL_CARRY: assert property (
        (commit_rot && st.op == round_rotate_pkg::rotate_left_op &&
         !st.dst_word) |=> st.ccr[`CCR_C] == $past(st.upper_word[15]))
        else $error("left rotate carry is not old bit 31");
    AST_ROR_CARRY: assert property (
        (commit_rot && st.op == round_rotate_pkg::rotate_right_op &&
         !st.dst_word) |=> st.ccr[`CCR_C] == $past(st.upper_word[0]) &&
        st.upper_word[15] == $past(st.ccr[`CCR_C]))
        else $error("right rotate carry path wrong");
    AST_ROT_KEEP: assert property (
        (commit_rot && !st.dst_word)
        |=> $stable(st.extension_portion) && $stable(st.lower_word))
        else $error("rotate disturbed extension or lower word");
    AST_ROT_FLAGS: assert property (
        commit_rot |=> !st.ccr[`CCR_V] &&
        st.ccr[`CCR_N] == (st.dst_word ? st.word[15] : st.upper_word[15]))
        else $error("rotate flags wrong");
    AST_ROL_DATA: assert property (
        (commit_rot && st.op == round_rotate_pkg::rotate_left_op &&
         !st.dst_word) |=> st.upper_word ==
        {$past(st.upper_word[14:0]), $past(st.ccr[`CCR_C])})
        else $error("left rotate data path wrong");
    AST_ROR_SHIFT: assert property (
        (commit_rot && st.op == round_rotate_pkg::rotate_right_op &&
         !st.dst_word)
        |=> st.upper_word[14:0] == $past(st.upper_word[15:1]))
        else $error("right rotate did not shift the upper word");
    AST_ROT_ZERO: assert property (
        commit_rot |=> st.ccr[`CCR_Z] ==
        ((st.dst_word ? st.word : st.upper_word) == 16'h0000))
        else $error("rotate zero flag wrong");
    AST_RND_OVF: assert property (
        commit_rnd |=> st.ccr[`CCR_V] == $past(!acc[35] && plain_sum[35]) &&
        (!st.ccr[`CCR_V] || st.ccr[`CCR_L]))
        else $error("round overflow or limit flag wrong");
    AST_RND_LIMIT: assert property (
        (commit_rnd && st.lim) |=> st.ccr[`CCR_L])
        else $error("limited move did not set the limit flag");
    AST_RND_NEG: assert property (
        (commit_rnd && !st.cc_width) |=> st.ccr[`CCR_N] ==
        (st.ccr[`CCR_V] ? $past(acc[35]) : st.extension_portion[3]))
        else $error("round negative flag wrong");
    AST_RND_WIDTH: assert property (
        (commit_rnd && st.cc_width)
        |=> st.ccr[`CCR_N] == st.upper_word[15] &&
        st.ccr[`CCR_Z] == (st.upper_word == 16'h0000))
        else $error("round flags ignore the width bit");
    AST_RND_EXT: assert property (
        commit_rnd |=> st.ccr[`CCR_E] == !(int_bits == 5'h00 || int_bits == 5'h1F))
        else $error("round extension flag wrong");
    AST_RND_SIZE: assert property (
        commit_rnd |=> st.ccr[`CCR_SZ] ==
        ($past(st.ccr[`CCR_SZ]) | (st.upper_word[14] ^ st.upper_word[13])))
        else $error("round size flag wrong");

    COV_RND_TIE: cover property (commit_rnd && st.lower_word == `HALF_LOWER);
    COV_ROL: cover property (commit_rot &&
        st.op == round_rotate_pkg::rotate_left_op);
    COV_ROR: cover property (commit_rot &&
        st.op == round_rotate_pkg::rotate_right_op);
    COV_RND_MOVE: cover property (start_op && nx.mvcnt != 4'h0);
    COV_CC_WIDTH: cover property (commit_rnd && st.cc_width);

endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "round_rotate_regs.svh"

module testbench;

    localparam int CYCLE_LIMIT = 20000;

    logic        clk_i = 1'b0;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        busy_o;
    int          failures;
    int          tests_run;
    int          cycles = 0;
    int          nb;
    logic [31:0] q;

    accumulator_round_rotate_unit accumulator_round_rotate_unit_inst (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cyc_i  (cyc_i),
        .stb_i  (stb_i),
        .we_i   (we_i),
        .adr_i  (adr_i),
        .sel_i  (sel_i),
        .dat_i  (dat_i),
        .dat_o  (dat_o),
        .ack_o  (ack_o),
        .busy_o (busy_o)
    );

    always #5 clk_i = ~clk_i;

    task automatic tally_and_finish;
        $display("Checks made: %0d, mismatches: %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A stuck bus ends the run here; a busy flag that never falls only ends count_busy after 40 cycles.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            failures++;
            $display("MISMATCH t=%0t cycle limit reached", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        // The design updates its outputs by non-blocking assignment, so at
        // each edge this reads the value that stood just before it.
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(1'b0, a, 32'h0000_0000, r);
    endtask

    task automatic count_busy(output int n);
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (busy_o !== 1'b1) begin
                break;
            end
            n++;
        end
    endtask

    task automatic rnd(input logic [35:0] acc, input logic [1:0] mode,
                       input logic [7:0] ctl, input logic [35:0] exp,
                       input logic [7:0] fl);
        logic [31:0] e;
        logic [31:0] u;
        logic [31:0] l;
        logic [31:0] c;
        int          n;
        wr(`OFF_MODE, {30'h0, mode});
        wr(`OFF_ACC_EXT, {28'h0, acc[35:32]});
        wr(`OFF_ACC_UPPER, {16'h0, acc[31:16]});
        wr(`OFF_ACC_LOWER, {16'h0, acc[15:0]});
        wr(`OFF_CCR, 32'h0000_0000);
        wr(`OFF_CTRL, {24'h0, ctl});
        count_busy(n);
        chk(36'(n), 36'(2 + ctl[7:4]), "round busy cycles");
        rd(`OFF_ACC_EXT, e);
        rd(`OFF_ACC_UPPER, u);
        rd(`OFF_ACC_LOWER, l);
        rd(`OFF_CCR, c);
        chk({e[3:0], u[15:0], l[15:0]}, exp, "round result");
        chk(36'(c[7:0]), 36'(fl), "round flags");
    endtask

    task automatic rot(input logic to_word, input logic left,
                       input logic [15:0] v, input logic [7:0] cin,
                       input logic [15:0] exp, input logic [7:0] cout);
        logic [31:0] e;
        logic [31:0] u;
        logic [31:0] l;
        logic [31:0] w;
        logic [31:0] c;
        int          n;
        wr(`OFF_ACC_EXT, 32'h0000_000F);
        wr(`OFF_ACC_UPPER, {16'h0, v});
        wr(`OFF_ACC_LOWER, 32'h0000_00AA);
        wr(`OFF_WORD, {16'h0, v});
        wr(`OFF_CCR, {24'h0, cin});
        wr(`OFF_CTRL, {29'h0, to_word, left ? 2'h2 : 2'h3});
        count_busy(n);
        chk(36'(n), 36'h2, "rotate busy cycles");
        rd(`OFF_ACC_EXT, e);
        rd(`OFF_ACC_UPPER, u);
        rd(`OFF_ACC_LOWER, l);
        rd(`OFF_WORD, w);
        rd(`OFF_CCR, c);
        chk({e[3:0], l[15:0], to_word ? u[15:0] : w[15:0]},
            {4'hF, 16'h00AA, v}, "rotate untouched parts");
        chk(36'(to_word ? w[15:0] : u[15:0]), 36'(exp), "rotate result");
        chk(36'(c[7:0]), 36'(cout), "rotate flags");
    endtask

    initial begin
        rst_i     = 1'b1;
        cyc_i     = 1'b0;
        stb_i     = 1'b0;
        we_i      = 1'b0;
        adr_i     = 8'h00;
        sel_i     = 4'hF;
        dat_i     = 32'h0000_0000;
        failures  = 0;
        tests_run = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;

        rd(`OFF_MODE, q);
        chk(36'(q), 36'(`MODE_RESET), "mode after reset");
        rd(`OFF_CCR, q);
        chk(36'(q), 36'(`CCR_RESET), "flags after reset");
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, q);
        chk(36'(q), 36'h0, "unmapped read");
        wr(`OFF_CCR, 32'h0000_01FF);
        rd(`OFF_CCR, q);
        chk(36'(q), 36'h0FF, "flag register write");
        $display("Test done: reset and registers");

        rnd(36'h5_1236_789A, 2'h0, 8'h01, 36'h5_1236_0000, 8'h30);
        rnd(36'h0_4000_0000, 2'h0, 8'h01, 36'h0_4000_0000, 8'h80);
        rnd(36'h0_1236_8000, 2'h0, 8'h01, 36'h0_1236_0000, 8'h10);
        rnd(36'h0_1235_8000, 2'h0, 8'h01, 36'h0_1236_0000, 8'h10);
        rnd(36'h0_1236_8000, 2'h1, 8'h01, 36'h0_1237_0000, 8'h10);
        rnd(36'h0_1235_8000, 2'h1, 8'h01, 36'h0_1236_0000, 8'h10);
        rnd(36'h0_0000_7FFF, 2'h0, 8'h01, 36'h0_0000_0000, 8'h14);
        rnd(36'hF_1234_0000, 2'h0, 8'h01, 36'hF_1234_0000, 8'h38);
        rnd(36'h0_8000_0000, 2'h0, 8'h01, 36'h0_8000_0000, 8'h20);
        rnd(36'h0_8000_0000, 2'h2, 8'h01, 36'h0_8000_0000, 8'h28);
        rnd(36'h1_0000_0000, 2'h2, 8'h01, 36'h1_0000_0000, 8'h34);
        rnd(36'h7_FFFF_8000, 2'h1, 8'h01, 36'h8_0000_0000, 8'h72);
        rnd(36'h0_1236_0000, 2'h0, 8'h39, 36'h0_1236_0000, 8'h50);
        rnd(36'h0_1236_0000, 2'h0, 8'hF1, 36'h0_1236_0000, 8'h10);
        $display("Test done: round");

        wr(`OFF_MODE, 32'h0000_0000);
        rot(1'b0, 1'b1, 16'h0000, 8'hF1, 16'h0001, 8'hF0);
        rot(1'b0, 1'b1, 16'h8000, 8'h02, 16'h0000, 8'h05);
        rot(1'b0, 1'b1, 16'h4001, 8'h00, 16'h8002, 8'h08);
        rot(1'b0, 1'b0, 16'h0001, 8'h00, 16'h0000, 8'h05);
        rot(1'b0, 1'b0, 16'h0000, 8'h01, 16'h8000, 8'h08);
        rot(1'b0, 1'b0, 16'hAAAA, 8'hF2, 16'h5555, 8'hF0);
        rot(1'b1, 1'b1, 16'h8001, 8'h00, 16'h0002, 8'h01);
        rot(1'b1, 1'b0, 16'h0001, 8'hF0, 16'h0000, 8'hF5);
        $display("Test done: rotate");

        // A long round leaves room for a command and an operand write to
        // arrive while busy; both must be dropped.
        wr(`OFF_ACC_EXT, 32'h0000_0000);
        wr(`OFF_ACC_UPPER, 32'h0000_0000);
        wr(`OFF_ACC_LOWER, 32'h0000_0000);
        wr(`OFF_CCR, 32'h0000_0001);
        wr(`OFF_CTRL, 32'h0000_00F1);
        wr(`OFF_CTRL, 32'h0000_0002);
        wr(`OFF_ACC_UPPER, 32'h0000_5555);
        rd(`OFF_CCR, q);
        chk(36'(q), 36'h101, "busy bit during round");
        count_busy(nb);
        rd(`OFF_ACC_UPPER, q);
        chk(36'(q), 36'h0000, "command during busy");
        rd(`OFF_CCR, q);
        chk(36'(q), 36'h15, "flags after dropped command");
        $display("Test done: command during busy");

        wr(`OFF_MODE, 32'h0000_0003);
        wr(`OFF_ACC_UPPER, 32'h0000_1234);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`OFF_MODE, q);
        chk(36'(q), 36'(`MODE_RESET), "mode after second reset");
        rd(`OFF_ACC_UPPER, q);
        chk(36'(q), 36'h0, "upper word after second reset");
        $display("Test done: reset in mid-run");

        tally_and_finish();
    end

endmodule

`default_nettype wire
